/* rtl/phy_link_level_loopback_ctrl.sv */
`timescale 1ns/1ps
`include "pll_cfg.svh"
// One PHY's transmit level, negotiation status and loopback control
module phy_link_level_loopback_ctrl
  import pll_pkg::*;
#(
  parameter int W = `PLL_WORD_W
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         soft_reset_i,           // Software reset pulse
  input  wire logic         high_swing_strap_i,     // Active low strap level
  input  wire logic         adv_high_swing_ability_i,
  input  wire logic         adv_high_swing_request_i,
  input  wire logic         adv_wr_i,               // Write strobe for both bits
  input  wire logic         negotiation_restart_request_i,
  input  wire logic         an_enable_i,            // Negotiation enabled
  input  wire logic         link_up_i,              // Core link indication
  input  wire logic         an_finished_i,          // Core finished pulse
  input  wire logic [3*W-1:0] partner_page_i,       // Partner base page
  input  wire logic [1:0]   partner_raddr_i,        // Word select
  input  wire logic         link_status_rd_i,       // Status read strobe
  input  wire logic         pma_local_loop_enable_i,
  input  wire logic         pcs_loop_enable_i,
  input  wire logic         host_side_loop_enable_i,
  input  wire logic         host_side_loop_tx_suppress_i,
  input  wire logic         suppress_wr_i,          // Write strobe for suppress
  input  wire logic         mac_tx_valid_i,
  input  wire logic [3:0]   mac_tx_data_i,
  input  wire logic         pcs_tx_valid_i,
  input  wire logic [3:0]   pcs_tx_data_i,
  input  wire logic         pcs_rx_valid_i,
  input  wire logic [3:0]   pcs_rx_data_i,
  output logic              high_swing_capable_o,
  output logic              adv_high_swing_ability_o,
  output logic              adv_high_swing_request_o,
  output logic              partner_high_swing_ability_o,
  output logic              partner_high_swing_request_o,
  output logic [W-1:0]      partner_word_o,
  output logic              negotiation_finished_indication_o,
  output logic              negotiation_done_flag_o,
  output logic              latched_link_up_o,
  output logic              negotiation_restart_request_o,
  output logic              pma_loop_o,
  output logic              pcs_loop_o,
  output logic              mdi_tx_en_o,
  output logic              core_tx_valid_o,
  output logic [3:0]        core_tx_data_o,
  output logic              host_rx_valid_o,
  output logic [3:0]        host_rx_data_o,
  output logic              suppress_o
);
  logic             rst_hold_r;     // High on the cycle after any reset
  logic             link_prev_r;    // Previous link level
  logic             link_drop;      // Falling edge of link
  logic             restart_go;     // Restart trigger
  logic             restart_busy;   // Restart in progress
  logic [W-1:0]     page_word;      // Registered partner word
  pll_an_state_type an_state_r;     // Negotiation progress

  // Mark the first cycle after hardware or software reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_hold_r <= 1'b1;
    end else begin
      rst_hold_r <= soft_reset_i;
    end
  end

  // Strap caught by clock after release, never by the async reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_swing_capable_o <= 1'b0;
    end else if (rst_hold_r) begin
      high_swing_capable_o <= ~high_swing_strap_i;  // [RULE1] [RULE2]
    end
  end

  // Advertisement bits, gated by the capability
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      adv_high_swing_ability_o <= 1'b0;
      adv_high_swing_request_o <= 1'b0;
    end else if (rst_hold_r) begin
      adv_high_swing_ability_o <= 1'b0;
      adv_high_swing_request_o <= 1'b0;
    end else if (!high_swing_capable_o) begin
      // Not capable: writes ignored, bits stay clear [RULE19]
      adv_high_swing_ability_o <= 1'b0;
      adv_high_swing_request_o <= 1'b0;
    end else if (adv_wr_i) begin
      // Only advertises; level is left to negotiation [RULE3] [RULE4] [RULE5]
      adv_high_swing_ability_o <= adv_high_swing_ability_i;
      adv_high_swing_request_o <= adv_high_swing_request_i;
    end
  end

  // Link edge detect, link input is synchronous
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_prev_r <= 1'b0;
    end else begin
      link_prev_r <= link_up_i;
    end
  end

  assign link_drop  = link_prev_r & ~link_up_i;
  // Drop with negotiation enabled, or host request, restarts [RULE11] [RULE12]
  assign restart_go = (link_drop & an_enable_i) | negotiation_restart_request_i;

  // Stretch restart so the core sees it for a minimum time
  pll_restart_timer u_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (restart_go),
    .busy_o  (restart_busy)
  );

  // Restart output registered from the timer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      negotiation_restart_request_o <= 1'b0;
    end else begin
      negotiation_restart_request_o <= restart_busy | restart_go;  // [RULE11] [RULE12]
    end
  end

  // Negotiation progress tracking
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      an_state_r <= PLL_IDLE;
    end else begin
      case (an_state_r)
        PLL_IDLE: begin
          if (an_enable_i) an_state_r <= PLL_NEGOTIATE;
        end
        PLL_RESTART: begin
          if (!restart_busy) an_state_r <= PLL_NEGOTIATE;
        end
        PLL_NEGOTIATE: begin
          if (restart_go) an_state_r <= PLL_RESTART;
          else if (an_finished_i) an_state_r <= PLL_DONE;
        end
        PLL_DONE: begin
          if (restart_go) an_state_r <= PLL_RESTART;
          else if (!an_enable_i) an_state_r <= PLL_IDLE;
        end
        default: an_state_r <= PLL_IDLE;
      endcase
    end
  end

  // Finished indication and done flag
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      negotiation_finished_indication_o <= 1'b0;
      negotiation_done_flag_o           <= 1'b0;
    end else begin
      // Set on completion, even while link still sets up [RULE7]
      negotiation_finished_indication_o <= (an_state_r == PLL_DONE) ||
                                           (an_state_r == PLL_NEGOTIATE && an_finished_i && !restart_go);
      // Done only with link up [RULE8]
      negotiation_done_flag_o <= (an_state_r == PLL_DONE) && link_up_i && !restart_go;
    end
  end

  // Partner page captured at completion so words are coherent [RULE6] [RULE8]
  pll_word_store #(.W(W)) u_store (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .wr_i    (an_state_r == PLL_NEGOTIATE && an_finished_i),
    .wdata_i (partner_page_i),
    .raddr_i (partner_raddr_i),
    .rdata_o (page_word)
  );

  // Partner word from the store, zero until first capture; upper bits zero until done [RULE6]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      partner_word_o               <= '0;
      partner_high_swing_ability_o <= 1'b0;
      partner_high_swing_request_o <= 1'b0;
    end else begin
      partner_word_o               <= page_word;
      partner_high_swing_ability_o <= negotiation_done_flag_o & partner_page_i[2*W + `PLL_HI_ABL_BIT];
      partner_high_swing_request_o <= negotiation_done_flag_o & partner_page_i[2*W + `PLL_HI_REQ_BIT];
    end
  end

  // Latch low: failure wins over the read that would reload it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      latched_link_up_o <= 1'b0;
    end else if (!link_up_i) begin
      latched_link_up_o <= 1'b0;  // [RULE9]
    end else if (link_status_rd_i) begin
      // Reread after a zero shows current link [RULE9] [RULE10]
      latched_link_up_o <= 1'b1;
    end
  end

  // Loop enables, registered from host bits
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pma_loop_o  <= `PLL_LOOP_RST;
      pcs_loop_o  <= `PLL_LOOP_RST;
      mdi_tx_en_o <= 1'b0;
    end else begin
      pma_loop_o  <= pma_local_loop_enable_i;  // [RULE14]
      pcs_loop_o  <= pcs_loop_enable_i;        // [RULE15]
      // No medium drive in PCS loop [RULE16]
      mdi_tx_en_o <= pcs_tx_valid_i & ~pcs_loop_enable_i;
    end
  end

  // Suppress bit defaults to set
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      suppress_o <= `PLL_SUPPRESS_RST;
    end else if (suppress_wr_i) begin
      suppress_o <= host_side_loop_tx_suppress_i;
    end
  end

  // MAC data into core, blocked while looping with suppress [RULE18]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_tx_valid_o <= 1'b0;
      core_tx_data_o  <= 4'h0;
    end else begin
      core_tx_valid_o <= mac_tx_valid_i & ~(host_side_loop_enable_i & suppress_o);
      core_tx_data_o  <= mac_tx_data_i;
    end
  end

  // Host receive path: MAC loop, PCS loop, or normal receive
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_rx_valid_o <= 1'b0;
      host_rx_data_o  <= 4'h0;
    end else if (host_side_loop_enable_i) begin
      host_rx_valid_o <= mac_tx_valid_i;  // [RULE17]
      host_rx_data_o  <= mac_tx_data_i;
    end else if (pcs_loop_enable_i) begin
      host_rx_valid_o <= pcs_tx_valid_i;  // [RULE15]
      host_rx_data_o  <= pcs_tx_data_i;
    end else begin
      host_rx_valid_o <= pcs_rx_valid_i;
      host_rx_data_o  <= pcs_rx_data_i;
    end
  end
endmodule : phy_link_level_loopback_ctrl

/* rtl/pll_cfg.svh */
// Overview of operation
// (RULE1) Strap sampled at reset; low enables high swing
// (RULE2) Capability status bit follows the captured strap
// (RULE3) Ability advertise bit only when capable
// (RULE4) Request advertise bit only when capable
// (RULE5) Ability only advertises; negotiation resolves level
// (RULE6) Partner upper bits valid after done flag
// (RULE7) Finished indication set on negotiation completion
// (RULE8) Done flag when finished and link up
// (RULE9) Link status latches low until read
// (RULE10) Host rereads link status after reading zero
// (RULE11) Link drop restarts negotiation automatically
// (RULE12) Host restart request restarts negotiation
// (RULE13) Host forces link, no termination, before PMA loop; code forces neither, pma_loop_o follows its enable alone
// (RULE14) PMA local loop enable places PHY in loop
// (RULE15) PCS loop routes transmit data to receiver
// (RULE16) PCS loop drives nothing onto medium
// (RULE17) Host side loop returns MAC data to host
// (RULE18) Suppress bit blocks MAC data into core
// (RULE19) Ability writes ignored when not capable
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH
`define PLL_WORD_W         16
`define PLL_HI_ABL_BIT     13
`define PLL_HI_REQ_BIT     12
`define PLL_SUPPRESS_RST   1'b1
`define PLL_LOOP_RST       1'b0
`define PLL_RESTART_NS     1000
`define PLL_CLK_NS         40
`define PLL_RESTART_CYC    ((`PLL_RESTART_NS + `PLL_CLK_NS - 1) / `PLL_CLK_NS)
`define PLL_CNT_W          8
`endif

/* rtl/pll_pkg.sv */
package pll_pkg;
  // Negotiation progress per PHY
  typedef enum logic [1:0] {
    PLL_IDLE,
    PLL_RESTART,
    PLL_NEGOTIATE,
    PLL_DONE
  } pll_an_state_type;
endpackage : pll_pkg

/* rtl/pll_restart_timer.sv */
`timescale 1ns/1ps
`include "pll_cfg.svh"
// Holds the negotiation restart pulse for a minimum time
module pll_restart_timer
  import pll_pkg::*;
#(
  parameter int CYC = `PLL_RESTART_CYC
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  output logic      busy_o
);
  logic [`PLL_CNT_W-1:0] cnt_r;  // Cycles left

  // Retrigger reloads so back to back restarts extend
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r  <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= CYC[`PLL_CNT_W-1:0];
      busy_o <= 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r  <= cnt_r - 8'h01;
      busy_o <= (cnt_r != 8'h01);
    end else begin
      busy_o <= 1'b0;
    end
  end
endmodule : pll_restart_timer

/* rtl/pll_word_store.sv */
`timescale 1ns/1ps
`include "pll_cfg.svh"
// Holds the three partner base page words, registered read out
module pll_word_store
  import pll_pkg::*;
#(
  parameter int W = `PLL_WORD_W
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             wr_i,
  input  wire logic [3*W-1:0]   wdata_i,
  input  wire logic [1:0]       raddr_i,
  output logic      [W-1:0]     rdata_o
);
  logic [W-1:0] mem_r [3];  // Lower, middle, upper word

  // Capture all words together so the page never mixes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 3; i++) mem_r[i] <= '0;
    end else if (wr_i) begin
      for (int i = 0; i < 3; i++) mem_r[i] <= wdata_i[i*W +: W];
    end
  end

  // Registered read; index 3 reads zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (raddr_i == 2'h3) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule : pll_word_store

/* tb/pll_checker_properties.sv */
`timescale 1ns/1ps
// Watches one PHY control block at its ports
module pll_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       high_swing_strap_i,
  input wire logic       negotiation_restart_request_i,
  input wire logic       an_enable_i,
  input wire logic       link_up_i,
  input wire logic       link_status_rd_i,
  input wire logic       pcs_loop_enable_i,
  input wire logic       host_side_loop_enable_i,
  input wire logic       suppress_wr_i,
  input wire logic       mac_tx_valid_i,
  input wire logic [3:0] mac_tx_data_i,
  input wire logic       high_swing_capable_o,
  input wire logic       adv_high_swing_ability_o,
  input wire logic       adv_high_swing_request_o,
  input wire logic       pma_local_loop_enable_i,
  input wire logic       pma_loop_o,
  input wire logic       negotiation_finished_indication_o,
  input wire logic       partner_high_swing_ability_o,
  input wire logic       negotiation_done_flag_o,
  input wire logic       latched_link_up_o,
  input wire logic       negotiation_restart_request_o,
  input wire logic       pcs_loop_o,
  input wire logic       mdi_tx_en_o,
  input wire logic       core_tx_valid_o,
  input wire logic       host_rx_valid_o,
  input wire logic [3:0] host_rx_data_o,
  input wire logic       suppress_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Restart must hold long enough for the partner to notice
  sequence s_restart_run;
    negotiation_restart_request_o [*8];
  endsequence
  a_strap_sets_capable: assert property (
    $changed(high_swing_capable_o) |-> high_swing_capable_o == !$past(high_swing_strap_i))
    else $error("capable bit not taken from strap");
  a_ability_needs_capable: assert property (
    adv_high_swing_ability_o |-> high_swing_capable_o)
    else $error("ability advertised while not capable");
  a_request_needs_capable: assert property (
    adv_high_swing_request_o |-> high_swing_capable_o)
    else $error("request advertised while not capable");
  a_done_implies_finished: assert property (
    negotiation_done_flag_o |-> negotiation_finished_indication_o)
    else $error("done flag without finished indication");
  a_pma_loop_follows: assert property (
    pma_local_loop_enable_i |=> pma_loop_o)
    else $error("pma loop not entered");
  a_partner_bits_valid: assert property (
    $rose(partner_high_swing_ability_o) |-> negotiation_done_flag_o || $past(negotiation_done_flag_o))
    else $error("partner bits shown before done");
  a_done_needs_link: assert property (
    negotiation_done_flag_o |-> $past(link_up_i) || $past(link_up_i, 2))
    else $error("done flag without link");
  a_link_latch_low: assert property (
    !link_up_i |=> !latched_link_up_o)
    else $error("link failure not latched");
  a_latch_holds_low: assert property (
    !latched_link_up_o && !link_status_rd_i |=> !latched_link_up_o)
    else $error("latched status rose without read");
  a_drop_restarts: assert property (
    $fell(link_up_i) && an_enable_i |-> ##[1:3] s_restart_run)
    else $error("no restart on link drop");
  a_host_restart: assert property (
    negotiation_restart_request_i |=> s_restart_run)
    else $error("no restart on request");
  a_pcs_loop_quiet: assert property (
    pcs_loop_enable_i |=> pcs_loop_o && !mdi_tx_en_o)
    else $error("medium driven in pcs loop");
  a_mac_loop_return: assert property (
    host_side_loop_enable_i && mac_tx_valid_i |=> host_rx_valid_o && host_rx_data_o == $past(mac_tx_data_i))
    else $error("mac data not returned to host");
  a_suppress_blocks_tx: assert property (
    host_side_loop_enable_i && suppress_o && !suppress_wr_i |=> !core_tx_valid_o)
    else $error("core fed while suppressed");
endmodule : pll_checker
bind phy_link_level_loopback_ctrl pll_checker u_chk (.*);

/* tb/pll_link_partner.sv */
`timescale 1ns/1ps
// Remote PHY: finishes negotiation on command, then brings link up
module pll_link_partner (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic go_i,       // Finish negotiation now
  input  wire logic drop_i,     // Lose the link now
  output logic      link_up_o,
  output logic      finished_o
);
  // Finished pulse precedes link up, as a real partner would
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      finished_o <= 1'b0;
      link_up_o  <= 1'b0;
    end else begin
      finished_o <= go_i;
      // Drop wins so a loss is never hidden
      if (drop_i) begin
        link_up_o <= 1'b0;
      end else if (finished_o) begin
        link_up_o <= 1'b1;
      end
    end
  end
endmodule : pll_link_partner

/* tb/testbench.sv */
`timescale 1ns/1ps
// Walks strap, advertisement, negotiation, link latch and loops
module testbench;
  localparam logic [47:0] PAGE = 48'h3A5C_1234_5678; // Upper word has both bits
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [6:0]  stb     = 7'h00;  // Strobes, one-hot
  logic        strap   = 1'b0;   // Low means capable
  logic        an_en   = 1'b1;
  logic [1:0]  raddr   = 2'h0;
  logic        pma     = 1'b0;
  logic        pcs     = 1'b0;
  logic        hsl     = 1'b0;
  logic        pcs_tv  = 1'b0;
  logic [3:0]  pcs_td  = 4'h0;
  logic        mac_v   = 1'b0;
  logic [3:0]  mac_d   = 4'h0;
  logic [47:0] page    = PAGE;
  logic [1:0]  advd    = 2'h3;   // Ability and request write data
  logic        sup_d   = 1'b0;   // Suppress write data
  logic [15:0] word;
  logic        cap, abl, req, pabl, preq, fin_ind, done, lat, rst_o, pma_o, pcs_o, mdi;
  logic        ctv, hrv, sup_o, link, fin;
  logic [3:0]  ctd, hrd;
  int          failures = 0;
  int          n_tests  = 0;
  int          cyc      = 0;
  always #20 clk_i = ~clk_i;
  pll_link_partner u_lp (.clk_i(clk_i), .reset_i(reset_i), .go_i(stb[5]), .drop_i(stb[6]),
    .link_up_o(link), .finished_o(fin));
  phy_link_level_loopback_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .soft_reset_i(stb[0]),
    .high_swing_strap_i(strap), .adv_high_swing_ability_i(advd[1]), .adv_high_swing_request_i(advd[0]),
    .adv_wr_i(stb[1]), .negotiation_restart_request_i(stb[2]), .an_enable_i(an_en), .link_up_i(link),
    .an_finished_i(fin), .partner_page_i(page), .partner_raddr_i(raddr), .link_status_rd_i(stb[3]),
    .pma_local_loop_enable_i(pma), .pcs_loop_enable_i(pcs), .host_side_loop_enable_i(hsl),
    .host_side_loop_tx_suppress_i(sup_d), .suppress_wr_i(stb[4]), .mac_tx_valid_i(mac_v),
    .mac_tx_data_i(mac_d), .pcs_tx_valid_i(pcs_tv), .pcs_tx_data_i(pcs_td), .pcs_rx_valid_i(1'b1),
    .pcs_rx_data_i(4'h9), .high_swing_capable_o(cap), .adv_high_swing_ability_o(abl),
    .adv_high_swing_request_o(req), .partner_high_swing_ability_o(pabl),
    .partner_high_swing_request_o(preq), .partner_word_o(word), .negotiation_finished_indication_o(fin_ind),
    .negotiation_done_flag_o(done), .latched_link_up_o(lat), .negotiation_restart_request_o(rst_o), .pma_loop_o(pma_o),
    .pcs_loop_o(pcs_o), .mdi_tx_en_o(mdi), .core_tx_valid_o(ctv), .core_tx_data_o(ctd),
    .host_rx_valid_o(hrv), .host_rx_data_o(hrd), .suppress_o(sup_o));
  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // Settle just past an edge
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // One-cycle strobe; a free edge follows so no double drive
  task strobe(input int k);
    @(posedge clk_i);
    stb <= 7'h01 << k;
    @(posedge clk_i);
    stb <= 7'h00;
    tick(2);
  endtask : strobe
  task finish_test;
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // Hang guard, far above the 160 or so cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    tick(2);
    check(16'(cap), 16'h1);
    check(16'(sup_o), 16'h1);
    check(16'(pabl), 16'h0);
    check({11'h0, hrv, hrd}, 16'h19);
    strobe(1);
    check({14'h0, abl, req}, 16'h3);
    @(posedge clk_i);
    strap <= 1'b1;
    strobe(0);
    check({14'h0, cap, abl}, 16'h0);
    strobe(1);
    check({14'h0, abl, req}, 16'h0);
    @(posedge clk_i);
    strap <= 1'b0;
    strobe(0);
    strobe(1);
    check({14'h0, cap, abl}, 16'h3);
    @(posedge clk_i);
    advd <= 2'h2;
    strobe(1);
    check({14'h0, abl, req}, 16'h2);
    strobe(5);
    tick(3);
    check({12'h0, fin_ind, done, pabl, preq}, 16'hF);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      raddr <= 2'(i);
      tick(3);
      check(word, (i == 3) ? 16'h0 : PAGE[16*i +: 16]);
    end
    strobe(3);
    check(16'(lat), 16'h1);
    strobe(6);
    check({14'h0, lat, rst_o}, 16'h1);
    tick(30);
    strobe(5);
    check(16'(lat), 16'h0);
    strobe(3);
    check(16'(lat), 16'h1);
    strobe(2);
    check(16'(rst_o), 16'h1);
    tick(15);
    check(16'(rst_o), 16'h1);
    tick(15);
    check(16'(rst_o), 16'h0);
    @(posedge clk_i);
    an_en  <= 1'b0;
    pma    <= 1'b1;
    pcs    <= 1'b1;
    pcs_tv <= 1'b1;
    pcs_td <= 4'h5;
    tick(2);
    check({12'h0, pma_o, pcs_o, mdi, hrv}, 16'hD);
    check(16'(hrd), 16'h5);
    @(posedge clk_i);
    pcs   <= 1'b0;
    hsl   <= 1'b1;
    mac_v <= 1'b1;
    mac_d <= 4'hA;
    tick(2);
    check({14'h0, mdi, ctv}, 16'h2);
    check(16'(hrd), 16'hA);
    strobe(4);
    check({11'h0, sup_o, ctv, ctd}, 16'h1A);
    @(posedge clk_i);
    sup_d <= 1'b1;
    strobe(4);
    check({14'h0, sup_o, ctv}, 16'h2);
    finish_test();
  end
endmodule : testbench
